// *** core/pacc_top.sv ***
// module: 16-bit pulse accumulator with APB register slave
`timescale 1ns/1ps
module pacc_top (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [pacc_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                 pwdata,
  input  wire logic [3:0]                  pstrb,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        shared_channel_pin,
  input  wire logic                        prescaler_tick,
  output logic                             timer_clk_tick,
  output logic                             overflow_irq,
  output logic                             edge_irq
);

  // ------------------------------------------------------------
  // register selects
  // ------------------------------------------------------------
  localparam int unsigned SEL_CTRL  = 0;
  localparam int unsigned SEL_FLAGS = 1;
  localparam int unsigned SEL_CNTH  = 2;
  localparam int unsigned SEL_CNTL  = 3;
  localparam int unsigned SEL_CNTW  = 4;
  localparam int unsigned SEL_TSC   = 5;
  localparam int unsigned NSEL      = 6;

  typedef struct packed {
    logic [7:0]  ctrl;
    logic [7:0]  tsc;
    logic [1:0]  flags;
    logic [15:0] count;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        tmr_tick;
    logic        irq_ovf;
    logic        irq_edge;
  } pacc_state_t;

  pacc_state_t r_reg;
  pacc_state_t r_next;

  logic pin_level;
  logic pin_rise;
  logic pin_fall;
  logic div64_tick;

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  function automatic logic [NSEL-1:0] decode(
    input logic [pacc_pkg::ADDR_W-1:0] a
  );
    logic [NSEL-1:0] s;
    s = '0;
    if (a == {pacc_pkg::IDX_CTRL, 2'b00}) begin
      s[SEL_CTRL] = 1'b1;
    end else if (a == {pacc_pkg::IDX_FLAGS, 2'b00}) begin
      s[SEL_FLAGS] = 1'b1;
    end else if (a == {pacc_pkg::IDX_CNTH, 2'b00}) begin
      s[SEL_CNTH] = 1'b1;
    end else if (a == {pacc_pkg::IDX_CNTL, 2'b00}) begin
      s[SEL_CNTL] = 1'b1;
    end else if (a == {pacc_pkg::IDX_CNTW, 2'b00}) begin
      s[SEL_CNTW] = 1'b1;
    end else if (a == {pacc_pkg::IDX_TSC, 2'b00}) begin
      s[SEL_TSC] = 1'b1;
    end
    return s;
  endfunction

  // ------------------------------------------------------------
  // count write helpers
  // ------------------------------------------------------------
  // true when a write strobe reaches either half of the count
  function automatic logic count_hit(
    input logic [NSEL-1:0] s,
    input logic [3:0]      b
  );
    return ((s[SEL_CNTH] || s[SEL_CNTL]) && b[0]) || (s[SEL_CNTW] && (b[0] || b[1]));
  endfunction

  // byte halves and the word register all land on the one count, so
  // only a word write loads both halves in the same cycle
  function automatic logic [15:0] count_merge(
    input logic [15:0]     c,
    input logic [NSEL-1:0] s,
    input logic [31:0]     d,
    input logic [3:0]      b
  );
    logic [15:0] n;
    n = c;
    if (s[SEL_CNTH] && b[0]) begin
      n[15:8] = d[7:0];
    end
    if (s[SEL_CNTL] && b[0]) begin
      n[7:0] = d[7:0];
    end
    if (s[SEL_CNTW] && b[0]) begin
      n[7:0] = d[7:0];
    end
    if (s[SEL_CNTW] && b[1]) begin
      n[15:8] = d[15:8];
    end
    return n;
  endfunction

  // ------------------------------------------------------------
  // read view
  // ------------------------------------------------------------
  // reserved and unmapped bits read zero; a word read sees both
  // count halves of the same cycle
  function automatic logic [31:0] read_word(
    input logic [NSEL-1:0] s,
    input pacc_state_t     r
  );
    logic [31:0] q;
    q = 32'h0000_0000;
    if (s[SEL_CTRL]) begin
      q[7:0] = r.ctrl;
    end else if (s[SEL_FLAGS]) begin
      q[1:0] = r.flags;
    end else if (s[SEL_CNTH]) begin
      q[7:0] = r.count[15:8];
    end else if (s[SEL_CNTL]) begin
      q[7:0] = r.count[7:0];
    end else if (s[SEL_CNTW]) begin
      q[15:0] = r.count;
    end else if (s[SEL_TSC]) begin
      q[7:0] = r.tsc;
    end
    return q;
  endfunction

  // ------------------------------------------------------------
  // pin synchroniser and gating divider
  // ------------------------------------------------------------
  pacc_pin_sync u_sync (
    .pclk      (pclk),
    .presetn   (presetn),
    .pin_async (shared_channel_pin),
    .level     (pin_level),
    .rise      (pin_rise),
    .fall      (pin_fall)
  );

  // the divider stands still with the timer off, so gated mode cannot count
  pacc_tick_div #(
    .DIV (pacc_pkg::GATE_DIV)
  ) u_div64 (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (r_reg.tsc[pacc_pkg::BIT_TEN]),
    .tick    (div64_tick)
  );

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  logic                    acc_en;
  logic                    gated;
  logic                    pol;
  logic                    edge_sel;
  logic                    gate_on;
  logic                    inc;
  logic                    set_ovf;
  logic                    set_edf;
  logic                    start;
  logic                    done;
  logic                    wr;
  logic [NSEL-1:0]         sel;
  logic                    cnt_acc;
  logic                    cnt_wr;
  logic                    clr_ok;
  logic [15:0]             cnt_new;
  pacc_pkg::pacc_clk_sel_t cs;

  always_comb begin
    r_next   = r_reg;
    acc_en   = r_reg.ctrl[pacc_pkg::BIT_EN];
    gated    = r_reg.ctrl[pacc_pkg::BIT_MOD];
    pol      = r_reg.ctrl[pacc_pkg::BIT_POL];
    sel      = decode(paddr);
    start    = psel && penable && !r_reg.pready;
    done     = psel && penable && r_reg.pready;
    wr       = done && pwrite;
    cnt_acc  = done && (sel[SEL_CNTH] || sel[SEL_CNTL] || sel[SEL_CNTW]);
    clr_ok   = r_reg.tsc[pacc_pkg::BIT_TEN] || acc_en;

    // event edge and trailing gate edge share one polarity choice
    edge_sel = pol ? pin_rise : pin_fall;
    gate_on  = pol ? !pin_level : pin_level;

    // mode only matters while enabled
    if (gated) begin
      inc = acc_en && gate_on && div64_tick;
    end else begin
      inc = acc_en && edge_sel;
    end
    set_edf = acc_en && edge_sel;

    // a count write in the same cycle wins over the increment
    cnt_wr  = wr && count_hit(sel, pstrb);
    if (cnt_wr) begin
      inc = 1'b0;
    end
    set_ovf = inc && (r_reg.count == pacc_pkg::COUNT_MAX);

    // ----------------------------------------------------------
    // count
    // ----------------------------------------------------------
    cnt_new = r_reg.count;
    if (inc) begin
      cnt_new = r_reg.count + 16'h0001;
    end
    if (wr) begin
      cnt_new = count_merge(cnt_new, sel, pwdata, pstrb);
    end
    r_next.count = cnt_new;

    // ----------------------------------------------------------
    // control registers
    // ----------------------------------------------------------
    if (wr && sel[SEL_CTRL] && pstrb[0]) begin
      r_next.ctrl = pwdata[7:0] & pacc_pkg::MASK_CTRL;
    end
    if (wr && sel[SEL_TSC] && pstrb[0]) begin
      r_next.tsc = pwdata[7:0] & pacc_pkg::MASK_TSC;
    end

    // ----------------------------------------------------------
    // flags: clear first, then hardware set wins
    // ----------------------------------------------------------
    if (wr && sel[SEL_FLAGS] && pstrb[0] && clr_ok) begin
      r_next.flags = r_reg.flags & ~pwdata[1:0];
    end
    if (cnt_acc && r_reg.tsc[pacc_pkg::BIT_FFCA] && clr_ok) begin
      r_next.flags = pacc_pkg::RST_FLAGS;
    end
    if (set_ovf) begin
      r_next.flags[pacc_pkg::BIT_OVF] = 1'b1;
    end
    if (set_edf) begin
      r_next.flags[pacc_pkg::BIT_EDF] = 1'b1;
    end

    // ----------------------------------------------------------
    // timer counter clock
    // ----------------------------------------------------------
    // select follows the register straight away, no boundary wait
    cs = pacc_pkg::pacc_clk_sel_t'(r_reg.ctrl[pacc_pkg::BIT_CSH:pacc_pkg::BIT_CSL]);
    if (!acc_en) begin
      cs = pacc_pkg::CS_PRESC;
    end
    case (cs)
      pacc_pkg::CS_PRESC: begin
        r_next.tmr_tick = prescaler_tick;
      end
      pacc_pkg::CS_ACLK: begin
        r_next.tmr_tick = inc;
      end
      pacc_pkg::CS_D256: begin
        r_next.tmr_tick = inc && (r_reg.count[7:0] == pacc_pkg::BYTE_MAX);
      end
      default: begin
        r_next.tmr_tick = set_ovf;
      end
    endcase

    // ----------------------------------------------------------
    // interrupt requests follow flag and enable of the same edge
    // ----------------------------------------------------------
    r_next.irq_ovf  = r_next.flags[pacc_pkg::BIT_OVF]
                      && r_next.ctrl[pacc_pkg::BIT_OVI];
    r_next.irq_edge = r_next.flags[pacc_pkg::BIT_EDF]
                      && r_next.ctrl[pacc_pkg::BIT_EDI];

    // ----------------------------------------------------------
    // apb answer: one wait state, read data latched with pready
    // ----------------------------------------------------------
    r_next.pready  = start;
    r_next.pslverr = start && (sel == '0);
    if (start) begin
      r_next.prdata = read_word(sel, r_reg);
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg          <= '0;
      r_reg.ctrl     <= pacc_pkg::RST_CTRL;
      r_reg.tsc      <= pacc_pkg::RST_TSC;
      r_reg.flags    <= pacc_pkg::RST_FLAGS;
      r_reg.count    <= pacc_pkg::RST_COUNT;
    end else begin
      r_reg <= r_next;
    end
  end

  // ------------------------------------------------------------
  // outputs, all straight from flip-flops
  // ------------------------------------------------------------
  assign prdata         = r_reg.prdata;
  assign pready         = r_reg.pready;
  assign pslverr        = r_reg.pslverr;
  assign timer_clk_tick = r_reg.tmr_tick;
  assign overflow_irq   = r_reg.irq_ovf;
  assign edge_irq       = r_reg.irq_edge;

endmodule

// *** core/pacc_pkg.sv ***
// package: register map, field positions and reset values of the pulse accumulator
package pacc_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam int unsigned ADDR_W = 10;
  localparam logic [7:0] IDX_CTRL  = 8'h20;
  localparam logic [7:0] IDX_FLAGS = 8'h21;
  localparam logic [7:0] IDX_CNTH  = 8'h22;
  localparam logic [7:0] IDX_CNTL  = 8'h23;
  localparam logic [7:0] IDX_CNTW  = 8'h24;
  localparam logic [7:0] IDX_TSC   = 8'h25;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int unsigned BIT_EN   = 6;
  localparam int unsigned BIT_MOD  = 5;
  localparam int unsigned BIT_POL  = 4;
  localparam int unsigned BIT_CSH  = 3;
  localparam int unsigned BIT_CSL  = 2;
  localparam int unsigned BIT_OVI  = 1;
  localparam int unsigned BIT_EDI  = 0;
  localparam int unsigned BIT_OVF  = 1;
  localparam int unsigned BIT_EDF  = 0;
  localparam int unsigned BIT_TEN  = 7;
  localparam int unsigned BIT_FFCA = 4;

  localparam logic [7:0] MASK_CTRL  = 8'h7f;
  localparam logic [7:0] MASK_FLAGS = 8'h03;
  localparam logic [7:0] MASK_TSC   = 8'h90;

  // ------------------------------------------------------------
  // reset values and counts
  // ------------------------------------------------------------
  localparam logic [7:0]  RST_CTRL  = 8'h00;
  localparam logic [7:0]  RST_TSC   = 8'h00;
  localparam logic [1:0]  RST_FLAGS = 2'h0;
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [7:0]  BYTE_MAX  = 8'hff;
  localparam int unsigned GATE_DIV  = 64;

  typedef enum logic [1:0] {
    CS_PRESC = 2'h0,
    CS_ACLK  = 2'h1,
    CS_D256  = 2'h2,
    CS_D64K  = 2'h3
  } pacc_clk_sel_t;

endpackage

// *** core/pacc_pin_sync.sv ***
// module: three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
module pacc_pin_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pin_async,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
    logic rise;
    logic fall;
  } pacc_sync_t;

  pacc_sync_t r_reg;
  pacc_sync_t r_next;

  // a level change is taken only once stages two and three agree
  always_comb begin
    r_next      = r_reg;
    r_next.s1   = pin_async;
    r_next.s2   = r_reg.s1;
    r_next.s3   = r_reg.s2;
    r_next.rise = 1'b0;
    r_next.fall = 1'b0;
    if (r_reg.s2 == r_reg.s3) begin
      r_next.lvl  = r_reg.s3;
      r_next.rise = r_reg.s3 && !r_reg.lvl;
      r_next.fall = !r_reg.s3 && r_reg.lvl;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign level = r_reg.lvl;
  assign rise  = r_reg.rise;
  assign fall  = r_reg.fall;

endmodule

// *** core/pacc_tick_div.sv ***
// module: enable-gated divider producing a one-cycle tick every DIV cycles
`timescale 1ns/1ps
module pacc_tick_div #(
  parameter int unsigned DIV = 64
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic run,
  output logic      tick
);

  localparam int unsigned CW = $clog2(DIV);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          tick;
  } pacc_div_t;

  pacc_div_t r_reg;
  pacc_div_t r_next;

  // stopped divider restarts from zero, so no stray tick on re-enable
  always_comb begin
    r_next      = r_reg;
    r_next.tick = 1'b0;
    if (!run) begin
      r_next.cnt = '0;
    end else if (r_reg.cnt == CW'(DIV - 1)) begin
      r_next.cnt  = '0;
      r_next.tick = 1'b1;
    end else begin
      r_next.cnt = r_reg.cnt + CW'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign tick = r_reg.tick;

endmodule

// *** dv/pacc_pulse_src.sv ***
// partner: pulse source driving the shared channel pin
`timescale 1ns/1ps
module pacc_pulse_src (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       start,
  input  wire logic [7:0] count,
  input  wire logic [7:0] hold,
  output logic            pin,
  output logic            busy
);
  // ----------------------------------------
  // pulse train, idle low
  // ----------------------------------------
  // each level holds for hold cycles; callers keep hold >= 3 so the
  // synchroniser agreement filter always sees the change
  logic [8:0] edges_reg;
  logic [7:0] cyc_reg;

  assign busy = (edges_reg != 9'h000);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edges_reg <= 9'h000;
      cyc_reg   <= 8'h00;
      pin       <= 1'b0;
    end else if (start && !busy) begin
      edges_reg <= {count, 1'b0};
      cyc_reg   <= hold;
    end else if (busy) begin
      if (cyc_reg <= 8'h01) begin
        pin       <= !pin;
        edges_reg <= edges_reg - 9'h001;
        cyc_reg   <= hold;
      end else begin
        cyc_reg <= cyc_reg - 8'h01;
      end
    end
  end
endmodule

// *** dv/pacc_asserts.sv ***
// checker: port-level assertions of the pulse accumulator
`timescale 1ns/1ps
module pacc_asserts (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [9:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        shared_channel_pin,
  input wire logic        prescaler_tick,
  input wire logic        timer_clk_tick,
  input wire logic        overflow_irq,
  input wire logic        edge_irq
);
  // ----------------------------------------
  // control shadow
  // ----------------------------------------
  logic [7:0] ctrl_reg;
  logic       ovi_on;
  logic       edi_on;
  logic       presc_sel;

  assign ovi_on    = ctrl_reg[1];
  assign edi_on    = ctrl_reg[0];
  assign presc_sel = !ctrl_reg[6] || (ctrl_reg[3:2] == 2'h0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= 8'h00;
    end else if (psel && penable && pready && pwrite && paddr == 10'h080 && pstrb[0]) begin
      ctrl_reg <= pwdata[7:0] & 8'h7f;
    end
  end

  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_access;
    psel && !penable ##1 psel && penable;
  endsequence
  sequence s_wrap_tick;
    ctrl_reg[6] && ctrl_reg[3:2] == 2'h3 && ovi_on && timer_clk_tick;
  endsequence

  property p_ready_wait;  s_access |-> !pready; endproperty
  property p_ready_next;  s_access |=> pready; endproperty
  property p_ready_pulse; pready |=> !pready; endproperty
  property p_err_map;
    pready && paddr[1:0] == 2'h0 |-> pslverr == !(paddr >= 10'h080 && paddr <= 10'h094);
  endproperty
  property p_err_only;    pslverr |-> pready; endproperty
  property p_ctrl_rsv;    pready && !pwrite && paddr == 10'h080 |-> prdata[31:7] == 25'h000_0000; endproperty
  property p_ovf_mask;    !ovi_on && !$past(ovi_on) |-> !overflow_irq; endproperty
  property p_edge_mask;   !edi_on && !$past(edi_on) |-> !edge_irq; endproperty
  property p_presc_sel;
    presc_sel && $past(presc_sel) |-> timer_clk_tick == $past(prescaler_tick);
  endproperty
  property p_ovf_tick;    s_wrap_tick |-> ##[0:2] overflow_irq; endproperty

  a_ready_wait:  assert property (p_ready_wait)  else $error("pready early");
  a_ready_next:  assert property (p_ready_next)  else $error("pready missing");
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready too long");
  a_err_map:     assert property (p_err_map)     else $error("pslverr wrong");
  a_err_only:    assert property (p_err_only)    else $error("pslverr alone");
  a_ctrl_rsv:    assert property (p_ctrl_rsv)    else $error("control reserved bits");
  a_ovf_mask:    assert property (p_ovf_mask)    else $error("overflow request masked");
  a_edge_mask:   assert property (p_edge_mask)   else $error("edge request masked");
  a_presc_sel:   assert property (p_presc_sel)   else $error("prescaler clock not used");
  a_ovf_tick:    assert property (p_ovf_tick)    else $error("wrap without overflow");
endmodule

// *** dv/pacc_top_bench.sv ***
// bench: self-checking testbench of the pulse accumulator
`timescale 1ns/1ps
module pacc_top_bench;
  logic        pclk     = 1'b0;
  logic        presetn  = 1'b0;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [9:0]  paddr    = 10'h000;
  logic [31:0] pwdata   = 32'h0000_0000;
  logic [3:0]  pstrb    = 4'hf;
  logic        prescaler_tick = 1'b0;
  logic        src_go   = 1'b0;
  logic [7:0]  src_n    = 8'h00;
  logic [7:0]  src_hold = 8'h04;
  logic [1:0]  pdiv     = 2'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pin;
  logic        src_busy;
  logic        timer_clk_tick;
  logic        overflow_irq;
  logic        edge_irq;
  int          bad_count = 0;
  int          cmp_count = 0;
  int          tick_cnt  = 0;

  always #4 pclk = ~pclk;

  // prescaler stand-in, held quiet in reset so the first checked edge is clean
  always @(posedge pclk) begin
    pdiv <= pdiv + 2'h1;
    prescaler_tick <= presetn && (pdiv == 2'h3);
    if (timer_clk_tick) begin
      tick_cnt <= tick_cnt + 1;
    end
  end

  pacc_top u_pacc_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .shared_channel_pin(pin), .prescaler_tick, .timer_clk_tick, .overflow_irq, .edge_irq);
  pacc_pulse_src u_pacc_pulse_src (.pclk, .presetn, .start(src_go), .count(src_n), .hold(src_hold),
    .pin(pin), .busy(src_busy));

  // ----------------------------------------
  // common tasks
  // ----------------------------------------
  task automatic test_done();
    $display("counts: %0d compared, %0d mismatched", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // entered just after a rising edge; pready is judged only at rising edges, where
  // read data is taken too; one idle edge follows release so no signal is driven twice
  task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      bad_count++;
      test_done();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rdc(input logic [9:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    chk(q, exp);
  endtask

  task automatic pulses(input logic [7:0] n, input logic [7:0] hold);
    int k;
    src_n <= n;
    src_hold <= hold;
    src_go <= 1'b1;
    @(posedge pclk);
    src_go <= 1'b0;
    k = 0;
    @(negedge pclk);
    while (src_busy === 1'b1 && k < 5000) begin
      k++;
      @(negedge pclk);
    end
    if (k == 5000) begin
      bad_count++;
      test_done();
    end
    // synchroniser and update lag before the count settles
    repeat (8) @(posedge pclk);
  endtask

  task automatic ticks(input int cyc, input int exp);
    int t0;
    t0 = tick_cnt;
    repeat (cyc) @(posedge pclk);
    chk(tick_cnt - t0, exp);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    logic [31:0] q;
    logic        e;
    for (int i = 0; i < 6; i++) rdc(10'h080 + 10'(4 * i), 32'h0000_0000);
    apb(1'b0, 10'h3fc, 32'h0000_0000, q, e);
    chk(e, 32'h0000_0001);
    wr(10'h080, 32'h0000_00ff);
    rdc(10'h080, 32'h0000_007f);
    wr(10'h094, 32'h0000_00ff);
    rdc(10'h094, 32'h0000_0090);
    wr(10'h080, 32'h0000_0000);
    wr(10'h094, 32'h0000_0000);
    $display("t_regs done");
  endtask

  task automatic t_event();
    wr(10'h080, 32'h0000_0041);
    wr(10'h090, 32'h0000_0000);
    pulses(8'h03, 8'h04);
    rdc(10'h090, 32'h0000_0003);
    rdc(10'h084, 32'h0000_0001);
    chk(edge_irq, 32'h0000_0001);
    wr(10'h080, 32'h0000_0051);
    wr(10'h090, 32'h0000_0000);
    pulses(8'h02, 8'h05);
    rdc(10'h090, 32'h0000_0002);
    $display("t_event done");
  endtask

  task automatic t_flags();
    wr(10'h080, 32'h0000_0001);
    wr(10'h084, 32'h0000_0003);
    rdc(10'h084, 32'h0000_0001);
    wr(10'h080, 32'h0000_0040);
    chk(edge_irq, 32'h0000_0000);
    wr(10'h084, 32'h0000_0000);
    rdc(10'h084, 32'h0000_0001);
    wr(10'h084, 32'h0000_0001);
    rdc(10'h084, 32'h0000_0000);
    $display("t_flags done");
  endtask

  task automatic t_ovf();
    int t0;
    wr(10'h080, 32'h0000_004e);
    wr(10'h090, 32'h0000_ffff);
    t0 = tick_cnt;
    pulses(8'h01, 8'h04);
    rdc(10'h090, 32'h0000_0000);
    rdc(10'h084, 32'h0000_0003);
    chk(overflow_irq, 32'h0000_0001);
    chk(tick_cnt - t0, 32'h0000_0001);
    wr(10'h094, 32'h0000_0010);
    rdc(10'h090, 32'h0000_0000);
    rdc(10'h084, 32'h0000_0000);
    wr(10'h094, 32'h0000_0000);
    wr(10'h080, 32'h0000_0048);
    wr(10'h090, 32'h0000_00fe);
    t0 = tick_cnt;
    pulses(8'h02, 8'h04);
    chk(tick_cnt - t0, 32'h0000_0001);
    $display("t_ovf done");
  endtask

  task automatic t_sel();
    int t0;
    wr(10'h080, 32'h0000_0044);
    ticks(40, 0);
    t0 = tick_cnt;
    pulses(8'h02, 8'h04);
    chk(tick_cnt - t0, 32'h0000_0002);
    wr(10'h080, 32'h0000_0004);
    ticks(40, 10);
    wr(10'h080, 32'h0000_0040);
    ticks(40, 10);
    $display("t_sel done");
  endtask

  task automatic t_gated();
    logic [31:0] q;
    logic        e;
    wr(10'h094, 32'h0000_0080);
    wr(10'h080, 32'h0000_0060);
    wr(10'h084, 32'h0000_0003);
    wr(10'h090, 32'h0000_0000);
    pulses(8'h01, 8'hc8);
    // 200 gated cycles hold three or four /64 ticks, depending on divider phase
    apb(1'b0, 10'h090, 32'h0000_0000, q, e);
    chk(q >= 32'h0000_0003 && q <= 32'h0000_0004, 32'h0000_0001);
    rdc(10'h084, 32'h0000_0001);
    wr(10'h094, 32'h0000_0000);
    wr(10'h090, 32'h0000_0000);
    pulses(8'h01, 8'hc8);
    rdc(10'h090, 32'h0000_0000);
    $display("t_gated done");
  endtask

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_event();
    t_flags();
    t_ovf();
    t_sel();
    t_gated();
    test_done();
  end
endmodule

bind pacc_top pacc_asserts u_pacc_asserts (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pstrb, .prdata, .pready, .pslverr, .shared_channel_pin, .prescaler_tick, .timer_clk_tick,
  .overflow_irq, .edge_irq);
